/* File: rtl/rts_regs.sv */
`timescale 1ns/1ps
`include "rts_defines.svh"
// Behaviour
// (RQ1) filter on: signed fraction byte has five bits, bits 2..0 read zero
// (RQ2) filter off: signed fraction byte has three bits, bits 4..0 read zero
// (RQ3) unsigned integer byte is plain binary, 128 down to 1 degree
// (RQ4) unsigned fraction byte: five bits filtered, three bits unfiltered
// (RQ5) reading an integer byte freezes its matching fraction byte
// (RQ6) reading the frozen fraction byte releases the freeze
// (RQ7) each new integer read refreshes the frozen fraction
// (RQ8) host should read integer byte first, then fraction byte
// (RQ9) diode config bit 6 picks address input or shutdown output
// (RQ10) diode config bits 5 and 4 mask diode fault from shutdown, critical
// (RQ11) diode config bit 3 picks processor or discrete transistor model
// (RQ12) filter field 00 disables, 11 enables, 01 and 10 reserved
// (RQ13) diode config bit 7 reads 0, bit 0 reads 1, resets to 1f
// (RQ14) offset is two's complement, high integer byte, low 3 fraction bits
// (RQ15) general config bit 6: 0 converts, 1 standby
// (RQ16) general config resets 00, four alarm masks, bits 7, 5, 0 zero
// (RQ17) rate code 00 continuous, 01 0.364 s, 10 1 s, 11 2.5 s
// (RQ18) conversion lasts 63 ms with diode, 33 ms when diode faulty
// (RQ19) rate register resets to 02, bits 7..2 read zero
// (RQ20) any write to one-shot starts one conversion in standby only; a write while a conversion still runs starts none
// (RQ21) one-shot write while active is ignored
// (RQ22) status bit 7 reads 1 while a conversion runs
// (RQ23) diode fault: unsigned reads 0, signed reads -128.000
module rts_regs #(
  parameter int unsigned CONV_CYC = `RTS_CONV_US * `RTS_CLK_MHZ,
  parameter int unsigned FAULT_CYC = `RTS_FAULT_CONV_US * `RTS_CLK_MHZ,
  parameter int unsigned RATE1_CYC = `RTS_RATE1_US * `RTS_CLK_MHZ,
  parameter int unsigned RATE2_CYC = `RTS_RATE2_US * `RTS_CLK_MHZ,
  parameter int unsigned RATE3_CYC = `RTS_RATE3_US * `RTS_CLK_MHZ
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData_r,
  output logic regRdValid_r,
  input wire logic signed [13:0] measTemp,
  input wire logic diodeFault,
  output rts_pkg::rts_dcfg_s diodeCfg_r,
  output rts_pkg::rts_gcfg_s genCfg_r,
  output logic [1:0] convRate_r,
  output logic convStart,
  output logic busy
);
  localparam logic [7:0] DCFG_RST = `RTS_DCFG_RST;
  localparam logic [7:0] GCFG_RST = `RTS_GCFG_RST;
  localparam logic [7:0] RATE_RST = `RTS_RATE_RST;

  generate
    if (RATE2_CYC < RATE1_CYC || RATE3_CYC < RATE2_CYC)
    begin : g_bad
      $error("rate periods must rise with the rate code");
    end
  endgenerate

  logic [7:0] offHigh_r, offLow_r;
  logic [7:0] sInt_r, uInt_r;
  logic [4:0] sFrac_r, uFrac_r, sFrozen_r, uFrozen_r;
  logic sLocked_r, uLocked_r, faultSeen_r;
  logic [7:0] rdAddr_r;
  wire logic convDone;
  wire logic filterOn;
  wire logic [7:0] rdMux;
  wire logic wrDcfg, wrGcfg, wrRate, wrOffH, wrOffL, wrOneShot;
  wire logic rdSInt, rdUInt, rdSFrac, rdUFrac;
  wire logic signed [14:0] adjTemp;
  wire logic [12:0] sSat, uSat;
  wire logic [4:0] sFracView, uFracView;

  // fraction byte with unused low bits forced to zero
  function automatic logic [7:0] fracByte(input logic [4:0] frac, input logic filt);
    fracByte = filt ? {frac, 3'h0} : {frac[4:2], 5'h00};
  endfunction

  // address decode
  assign wrDcfg = regWrEn && (regAddr == `RTS_A_DCFG);
  assign wrGcfg = regWrEn && (regAddr == `RTS_A_GCFG || regAddr == `RTS_A_GCFG_ALT);
  assign wrRate = regWrEn && (regAddr == `RTS_A_RATE || regAddr == `RTS_A_RATE_ALT);
  assign wrOffH = regWrEn && (regAddr == `RTS_A_OFFH);
  assign wrOffL = regWrEn && (regAddr == `RTS_A_OFFL);
  assign wrOneShot = regWrEn && (regAddr == `RTS_A_ONESHOT) && genCfg_r.standby; // see RQ20
  assign rdSInt = regRdEn && (regAddr == `RTS_A_SINT);
  assign rdUInt = regRdEn && (regAddr == `RTS_A_UINT);
  assign rdSFrac = regRdEn && (regAddr == `RTS_A_SFRAC);
  assign rdUFrac = regRdEn && (regAddr == `RTS_A_UFRAC);

  // reserved filter codes leave the filter off
  assign filterOn = (diodeCfg_r.filterField == `RTS_FILT_ON); // see RQ12

  // measured value plus signed offset, in 1/32 degree
  assign adjTemp = {measTemp[13], measTemp} +
                   {{2{offHigh_r[7]}}, offHigh_r, offLow_r[7:5], 2'h0}; // see RQ14
  assign sSat = (adjTemp > 15'sd4095) ? 13'h0fff :
                (adjTemp < -15'sd4096) ? 13'h1000 : adjTemp[12:0];
  assign uSat = (adjTemp < 15'sd0) ? 13'h0000 :
                (adjTemp > 15'sd8191) ? 13'h1fff : adjTemp[12:0];

  // fraction seen by the host: frozen copy while locked
  assign sFracView = sLocked_r ? sFrozen_r : sFrac_r;
  assign uFracView = uLocked_r ? uFrozen_r : uFrac_r;

  // read data select, unmapped offsets read zero
  assign rdMux =
    (regAddr == `RTS_A_SINT) ? sInt_r :
    (regAddr == `RTS_A_UINT) ? uInt_r : // see RQ3
    (regAddr == `RTS_A_SFRAC) ? fracByte(sFracView, filterOn) : // see RQ1
    (regAddr == `RTS_A_UFRAC) ? fracByte(uFracView, filterOn) : // see RQ4
    (regAddr == `RTS_A_STAT) ? {busy, 4'h0, faultSeen_r, 2'h0} : // see RQ22
    (regAddr == `RTS_A_DCFG) ? {1'b0, diodeCfg_r, 1'b1} : // see RQ13
    (regAddr == `RTS_A_GCFG || regAddr == `RTS_A_GCFG_ALT) ?
      {1'b0, genCfg_r.standby, 1'b0, genCfg_r.remoteCritMask,
       genCfg_r.remoteOsMask, genCfg_r.localCritMask,
       genCfg_r.localOsMask, 1'b0} : // see RQ16
    (regAddr == `RTS_A_RATE || regAddr == `RTS_A_RATE_ALT) ?
      {6'h00, convRate_r} : // see RQ19
    (regAddr == `RTS_A_OFFH) ? offHigh_r :
    (regAddr == `RTS_A_OFFL) ? offLow_r : 8'h00;

  // configuration registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      diodeCfg_r <= DCFG_RST[6:1]; // see RQ13
      genCfg_r <= {GCFG_RST[6], GCFG_RST[4:1]}; // see RQ16
      convRate_r <= RATE_RST[1:0]; // see RQ19
      offHigh_r <= `RTS_OFF_RST;
      offLow_r <= `RTS_OFF_RST;
    end
    else
    begin
      if (wrDcfg)
        diodeCfg_r <= regWrData[6:1]; // see RQ9, see RQ10, see RQ11
      if (wrGcfg)
        genCfg_r <= {regWrData[6], regWrData[4:1]}; // see RQ15
      if (wrRate)
        convRate_r <= regWrData[1:0]; // see RQ17
      if (wrOffH)
        offHigh_r <= regWrData;
      if (wrOffL)
        offLow_r <= regWrData & `RTS_OFFL_MASK; // see RQ14
    end
  end

  // results captured at the end of each conversion
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sInt_r <= 8'h80;
      sFrac_r <= 5'h00;
      uInt_r <= 8'h00;
      uFrac_r <= 5'h00;
      faultSeen_r <= 1'b0;
    end
    else if (convDone)
    begin
      faultSeen_r <= diodeFault;
      sInt_r <= diodeFault ? 8'h80 : sSat[12:5]; // see RQ23
      sFrac_r <= diodeFault ? 5'h00 : sSat[4:0];
      uInt_r <= diodeFault ? 8'h00 : uSat[12:5]; // see RQ23
      uFrac_r <= diodeFault ? 5'h00 : uSat[4:0];
    end
  end

  // fraction freeze: set on integer read, cleared on fraction read
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sLocked_r <= 1'b0;
      uLocked_r <= 1'b0;
      sFrozen_r <= 5'h00;
      uFrozen_r <= 5'h00;
    end
    else
    begin
      if (rdSInt)
      begin
        sLocked_r <= 1'b1; // see RQ5
        sFrozen_r <= sFrac_r; // see RQ7
      end
      else if (rdSFrac)
        sLocked_r <= 1'b0; // see RQ6
      if (rdUInt)
      begin
        uLocked_r <= 1'b1; // see RQ5
        uFrozen_r <= uFrac_r; // see RQ7
      end
      else if (rdUFrac)
        uLocked_r <= 1'b0; // see RQ6
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      regRdData_r <= 8'h00;
      regRdValid_r <= 1'b0;
      rdAddr_r <= 8'h00;
    end
    else
    begin
      regRdData_r <= regRdEn ? rdMux : regRdData_r;
      regRdValid_r <= regRdEn;
      rdAddr_r <= regRdEn ? regAddr : rdAddr_r;
    end
  end

  // conversion timing; one-shot only reaches it in standby
  rts_conv_sched #(
    .CONV_CYC(CONV_CYC),
    .FAULT_CYC(FAULT_CYC),
    .RATE1_CYC(RATE1_CYC),
    .RATE2_CYC(RATE2_CYC),
    .RATE3_CYC(RATE3_CYC)
  ) u_sched (
    .mclk(mclk),
    .rst(rst),
    .standby(genCfg_r.standby),
    .rate(convRate_r),
    .oneShot(wrOneShot), // see RQ21
    .diodeFault(diodeFault),
    .busy_r(busy),
    .convStart_r(convStart),
    .convDone_r(convDone)
  );

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sFracReadOut;
    regRdValid_r && (rdAddr_r == `RTS_A_SFRAC || rdAddr_r == `RTS_A_UFRAC);
  endsequence

  chk_frac_filter_on: assert property ( // see RQ1
    sFracReadOut ##0 $past(filterOn) |-> regRdData_r[2:0] == 3'h0)
    else $error("filtered fraction low bits not zero");
  chk_frac_filter_off: assert property ( // see RQ2
    sFracReadOut ##0 !$past(filterOn) |-> regRdData_r[4:0] == 5'h00)
    else $error("unfiltered fraction low bits not zero");

  sequence sIntRead;
    rdSInt && !convDone;
  endsequence
  sequence sFracReadNext;
    ##1 (!rdSInt && !convDone) [*1] ##1 rdSFrac;
  endsequence
  chk_lock_holds: assert property ( // see RQ5
    sIntRead ##0 sFracReadNext |=>
      regRdData_r[7:3] == ($past(sFrac_r, 3) & ($past(filterOn) ? 5'h1f : 5'h1c)))
    else $error("frozen fraction lost its sample");
  chk_lock_release: assert property ( // see RQ6
    rdSFrac && !rdSInt |=> !sLocked_r)
    else $error("fraction stayed frozen after read");
  chk_lock_refresh: assert property ( // see RQ7
    rdUInt |=> uLocked_r && uFrozen_r == $past(uFrac_r))
    else $error("second integer read did not refresh freeze");
  chk_dcfg_fixed_bits: assert property ( // see RQ13
    regRdValid_r && rdAddr_r == `RTS_A_DCFG |-> regRdData_r[7] == 1'b0 && regRdData_r[0])
    else $error("diode config fixed bits wrong");
  chk_gcfg_reserved: assert property ( // see RQ16
    regRdValid_r && rdAddr_r == `RTS_A_GCFG |-> (regRdData_r & 8'ha1) == 8'h00)
    else $error("general config reserved bits not zero");
  chk_rate_reserved: assert property ( // see RQ19
    regRdValid_r && rdAddr_r == `RTS_A_RATE |-> regRdData_r[7:2] == 6'h00)
    else $error("rate register upper bits not zero");
  chk_oneshot_start: assert property ( // see RQ20
    wrOneShot && !busy && !convStart |=> convStart && busy)
    else $error("one-shot in standby did not start a conversion");
  chk_oneshot_ignored: assert property ( // see RQ21
    regWrEn && regAddr == `RTS_A_ONESHOT && !genCfg_r.standby && busy |=> busy || convDone)
    else $error("one-shot disturbed an active conversion");
  chk_busy_status: assert property ( // see RQ22
    regRdEn && regAddr == `RTS_A_STAT |=> regRdData_r[`RTS_STAT_BUSY] == $past(busy))
    else $error("status busy bit does not follow conversion");
  chk_fault_result: assert property ( // see RQ23
    convDone && diodeFault |=> uInt_r == 8'h00 && sInt_r == 8'h80 && sFrac_r == 5'h00)
    else $error("diode fault result not forced");
endmodule // rts_regs

/* File: include/rts_defines.svh */
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH
// register offsets on the byte register port
`define RTS_A_SINT 8'h01
`define RTS_A_STAT 8'h02
`define RTS_A_GCFG 8'h03
`define RTS_A_GCFG_ALT 8'h09
`define RTS_A_RATE 8'h04
`define RTS_A_RATE_ALT 8'h0a
`define RTS_A_ONESHOT 8'h0f
`define RTS_A_SFRAC 8'h10
`define RTS_A_OFFH 8'h11
`define RTS_A_OFFL 8'h12
`define RTS_A_UINT 8'h31
`define RTS_A_UFRAC 8'h32
`define RTS_A_DCFG 8'hbf
// reset values
`define RTS_DCFG_RST 8'h1f
`define RTS_GCFG_RST 8'h00
`define RTS_RATE_RST 8'h02
`define RTS_OFF_RST 8'h00
// field positions
`define RTS_STAT_BUSY 7
`define RTS_STAT_FAULT 2
`define RTS_OFFL_MASK 8'he0
`define RTS_FILT_ON 2'h3
// timing, figures in microseconds at a clock in MHz
`define RTS_CLK_MHZ 250
`define RTS_CONV_US 63000
`define RTS_FAULT_CONV_US 33000
`define RTS_RATE1_US 364000
`define RTS_RATE2_US 1000000
`define RTS_RATE3_US 2500000
`endif

/* File: include/rts_pkg.sv */
package rts_pkg;
  // conversion scheduler states, gray along idle-conv-wait
  typedef enum logic [1:0] {
    RTS_IDLE = 2'b00,
    RTS_CONV = 2'b01,
    RTS_WAIT = 2'b11
  } rts_sched_e;

  // diode configuration fields, bits 6 to 1
  typedef struct packed {
    logic shutdownPinSel;
    logic osFaultMask;
    logic critFaultMask;
    logic procModel;
    logic [1:0] filterField;
  } rts_dcfg_s;

  // general configuration fields
  typedef struct packed {
    logic standby;
    logic remoteCritMask;
    logic remoteOsMask;
    logic localCritMask;
    logic localOsMask;
  } rts_gcfg_s;
endpackage

/* File: rtl/rts_conv_sched.sv */
`timescale 1ns/1ps
module rts_conv_sched #(
  parameter int unsigned CONV_CYC = 1,
  parameter int unsigned FAULT_CYC = 1,
  parameter int unsigned RATE1_CYC = 1,
  parameter int unsigned RATE2_CYC = 1,
  parameter int unsigned RATE3_CYC = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic standby,
  input wire logic [1:0] rate,
  input wire logic oneShot,
  input wire logic diodeFault,
  output logic busy_r,
  output logic convStart_r,
  output logic convDone_r
);
  rts_pkg::rts_sched_e state_r, state_nxt;
  logic [31:0] cnt_r, per_r, convLen_r;
  wire logic [31:0] interval;
  wire logic startNow, convEnd;

  generate
    if (CONV_CYC < 1 || FAULT_CYC < 1 || RATE1_CYC < 1)
    begin : g_bad
      $error("conversion counts must be at least one cycle");
    end
  endgenerate

  // period per rate code, continuous restarts after a single wait cycle
  assign interval = (rate == 2'h0) ? 32'h0 :
                    (rate == 2'h1) ? RATE1_CYC :
                    (rate == 2'h2) ? RATE2_CYC : RATE3_CYC; // see RQ17
  assign convEnd = (state_r == rts_pkg::RTS_CONV) && (cnt_r >= convLen_r);
  // a one-shot that lands in the single wait cycle after standby is still served
  assign startNow = ((state_r == rts_pkg::RTS_IDLE) && (!standby || oneShot)) ||
                    ((state_r == rts_pkg::RTS_WAIT) &&
                     (standby ? oneShot : (per_r >= interval))); // see RQ20

  // next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rts_pkg::RTS_IDLE: if (startNow) state_nxt = rts_pkg::RTS_CONV;
      rts_pkg::RTS_CONV: if (convEnd) state_nxt = standby ? rts_pkg::RTS_IDLE : rts_pkg::RTS_WAIT;
      rts_pkg::RTS_WAIT:
        if (startNow) state_nxt = rts_pkg::RTS_CONV;
        else if (standby) state_nxt = rts_pkg::RTS_IDLE; // see RQ15
      default: state_nxt = rts_pkg::RTS_IDLE;
    endcase
  end

  // counters and strobes
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= rts_pkg::RTS_IDLE;
      cnt_r <= 32'h0;
      per_r <= 32'h0;
      convLen_r <= 32'h1;
      busy_r <= 1'b0;
      convStart_r <= 1'b0;
      convDone_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= startNow ? 32'h1 : cnt_r + 32'h1;
      per_r <= startNow ? 32'h1 : per_r + 32'h1;
      if (startNow)
        convLen_r <= diodeFault ? FAULT_CYC : CONV_CYC; // see RQ18
      busy_r <= (state_nxt == rts_pkg::RTS_CONV); // see RQ22
      convStart_r <= startNow;
      convDone_r <= convEnd;
    end
  end

  chk_standby_halts: assert property (@(posedge mclk) disable iff (rst)
    (state_r == rts_pkg::RTS_WAIT) && standby && !oneShot |=> !busy_r) // see RQ15
    else $error("standby did not stop periodic conversion");
endmodule // rts_conv_sched

/* File: testbench/rts_host_model.sv */
`timescale 1ns/1ps
module rts_host_model (
  input wire logic mclk,
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData_r,
  input wire logic regRdValid_r
);
  // idle bus at time zero
  initial
  begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // one write strobe, taken at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge mclk);
    #1;
    regWrEn = 1'b0;
    regWrData = ~d;  // released data no longer shows the old byte
  endtask

  // one read strobe; answer is settled just after the edge that takes it
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge mclk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData_r;
    v = regRdValid_r;
  endtask

  // integer byte first, then its fraction, for a coherent value
  task automatic rdPair(input logic [7:0] a, output logic [7:0] hi, output logic [7:0] lo);
    logic v;
    rd(a, hi, v);
    rd(a ^ 8'h11 ^ ((a == 8'h31) ? 8'h12 : 8'h00), lo, v);
  endtask
endmodule // rts_host_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic mclk;
  logic rst;
  logic [7:0] regAddr;
  logic regWrEn;
  logic [7:0] regWrData;
  logic regRdEn;
  logic [7:0] regRdData_r;
  logic regRdValid_r;
  logic signed [13:0] measTemp;
  logic diodeFault;
  rts_pkg::rts_dcfg_s diodeCfg_r;
  rts_pkg::rts_gcfg_s genCfg_r;
  logic [1:0] convRate_r;
  logic convStart;
  logic busy;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int lastStart = 0;
  int startIv = 0;
  int starts = 0;
  int n;
  int s;
  int lo[4] = '{20, 40, 60, 80};
  logic [7:0] pHi;
  logic [7:0] pLo;

  rts_regs #(.CONV_CYC(20), .FAULT_CYC(10), .RATE1_CYC(40), .RATE2_CYC(60), .RATE3_CYC(80))
  dut_u (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
    .regRdValid_r(regRdValid_r), .measTemp(measTemp), .diodeFault(diodeFault),
    .diodeCfg_r(diodeCfg_r), .genCfg_r(genCfg_r), .convRate_r(convRate_r),
    .convStart(convStart), .busy(busy));

  rts_host_model host_u (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
    .regRdValid_r(regRdValid_r));

  // 250 MHz clock
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // conversion start monitor: count and spacing of starts
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (convStart === 1'b1)
    begin
      startIv <= cyc - lastStart;
      lastStart <= cyc;
      starts <= starts + 1;
    end
  end

  task automatic print_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // read a byte and expect a valid answer with the given value
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.rd(a, d, v);
    check({7'h00, v, d}, {8'h01, exp});
  endtask

  task automatic waitLevel(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 300)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 300)
      errors++;
  endtask

  task automatic waitStart();
    int k;
    int s0;
    k = 0;
    s0 = starts;
    while (starts == s0 && k < 300)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 300)
      errors++;
  endtask

  // one-shot conversion of a given temperature; returns busy length
  task automatic conv(input logic signed [13:0] t, input logic f, output int len);
    measTemp = t;
    diodeFault = f;
    host_u.wr(8'h0f, 8'h5a);
    waitLevel(1'b1);
    len = 0;
    while (busy === 1'b1 && len < 300)
    begin
      @(posedge mclk);
      #1;
      len++;
    end
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    measTemp = 14'sd819;
    diodeFault = 1'b0;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    rdChk(8'hbf, 8'h1f);
    rdChk(8'h03, 8'h00);
    rdChk(8'h04, 8'h02);
    rdChk(8'h11, 8'h00);
    rdChk(8'h12, 8'h00);
    host_u.wr(8'h03, 8'hff);
    rdChk(8'h09, 8'h5e);
    check(16'(genCfg_r), 16'h001f);
    waitLevel(1'b0);
    rdChk(8'h0f, 8'h00);
    host_u.wr(8'h0a, 8'hff);
    rdChk(8'h04, 8'h03);
    check(16'(convRate_r), 16'h0003);
    // walk one bit through each diode configuration field
    for (int i = 1; i < 7; i++)
    begin
      host_u.wr(8'hbf, 8'h01 << i);
      rdChk(8'hbf, (8'h01 << i) | 8'h01);
      check(16'(diodeCfg_r), 16'h0001 << (i - 1));
    end
    host_u.wr(8'hbf, 8'hff);
    rdChk(8'hbf, 8'h7f);
    host_u.wr(8'hbf, 8'h1f);
    host_u.wr(8'h12, 8'hff);
    rdChk(8'h12, 8'he0);
    host_u.wr(8'h11, 8'h01);
    host_u.wr(8'h12, 8'h80);
    s = starts;
    conv(14'sd819, 1'b0, n);
    check(16'(n), 16'd20);
    repeat (100) @(posedge mclk);
    #1;
    check(16'(starts - s), 16'h0001);
    rdChk(8'h31, 8'h1b);
    rdChk(8'h32, 8'h18);
    host_u.wr(8'h11, 8'h00);
    host_u.wr(8'h12, 8'h00);
    conv(14'sd819, 1'b0, n);
    rdChk(8'h01, 8'h19);
    rdChk(8'h10, 8'h98);
    host_u.wr(8'hbf, 8'h19);
    rdChk(8'h10, 8'h80);
    rdChk(8'h32, 8'h80);
    host_u.wr(8'hbf, 8'h1b);
    rdChk(8'h10, 8'h80);
    host_u.wr(8'hbf, 8'h1f);
    conv(-14'sd328, 1'b0, n);
    rdChk(8'h01, 8'hf5);
    rdChk(8'h10, 8'hc0);
    // freeze, release and refreeze of the fraction byte
    conv(14'sd819, 1'b0, n);
    rdChk(8'h31, 8'h19);
    conv(14'sd968, 1'b0, n);
    rdChk(8'h32, 8'h98);
    rdChk(8'h32, 8'h40);
    rdChk(8'h31, 8'h1e);
    conv(14'sd819, 1'b0, n);
    rdChk(8'h31, 8'h19);
    rdChk(8'h32, 8'h98);
    host_u.rdPair(8'h31, pHi, pLo);
    check({pHi, pLo}, 16'h1998);
    // busy flag in status, then a faulty diode
    measTemp = 14'sd819;
    host_u.wr(8'h0f, 8'h00);
    waitLevel(1'b1);
    rdChk(8'h02, 8'h80);
    waitLevel(1'b0);
    rdChk(8'h02, 8'h00);
    conv(14'sd819, 1'b1, n);
    check(16'(n), 16'd10);
    rdChk(8'h31, 8'h00);
    rdChk(8'h32, 8'h00);
    rdChk(8'h01, 8'h80);
    rdChk(8'h10, 8'h00);
    rdChk(8'h02, 8'h04);
    diodeFault = 1'b0;
    // periodic rates while active
    host_u.wr(8'h03, 8'h00);
    for (int r = 0; r < 4; r++)
    begin
      host_u.wr(8'h04, 8'(r));
      waitStart();
      waitStart();
      check(16'(startIv >= lo[r] && startIv <= lo[r] + 2), 16'h0001);
    end
    waitLevel(1'b0);
    s = starts;
    host_u.wr(8'h0f, 8'h00);
    repeat (30) @(posedge mclk);
    #1;
    check(16'(starts - s), 16'h0000);
    waitStart();
    check(16'(startIv >= 80 && startIv <= 82), 16'h0001);
    // one-shot during a running conversion must not shift the schedule
    host_u.wr(8'h0f, 8'h00);
    waitStart();
    check(16'(startIv >= 80 && startIv <= 82), 16'h0001);
    // standby entered between periodic conversions stops them
    waitLevel(1'b0);
    host_u.wr(8'h03, 8'h40);
    s = starts;
    repeat (100) @(posedge mclk);
    #1;
    check(16'(starts - s), 16'h0000);
    print_verdict();
  end

  // watchdog against a hung handshake
  initial
  begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule // tb_top
